// File: hdl/crcu_pkg.sv
package crcu_pkg;

   // register byte offsets
   localparam logic [7:0]  CRCU_OFS_CTRL     = 8'h00;
   localparam logic [7:0]  CRCU_OFS_SEED     = 8'h04;
   localparam logic [7:0]  CRCU_OFS_SUM      = 8'h08;
   localparam logic [7:0]  CRCU_OFS_DATA     = 8'h0C;
   localparam logic [7:0]  CRCU_OFS_STAT     = 8'h10;

   // control and status fields
   localparam int          CRCU_CTRL_W       = 8;
   localparam int          CRCU_MODE_LSB     = 0;
   localparam int          CRCU_DAT_CMPL     = 2;
   localparam int          CRCU_DAT_BYTE_REV = 3;
   localparam int          CRCU_DAT_BIT_REV  = 4;
   localparam int          CRCU_SUM_CMPL     = 5;
   localparam int          CRCU_SUM_BYTE_REV = 6;
   localparam int          CRCU_SUM_BIT_REV  = 7;
   localparam int          CRCU_STAT_BUSY    = 0;

   // reset values
   localparam logic [7:0]  CRCU_CTRL_RST     = 8'h00;
   localparam logic [31:0] CRCU_SEED_RST     = 32'h0000_0000;

   // polynomial modes
   localparam logic [1:0]  CRCU_MODE_CRC16   = 2'h0;
   localparam logic [1:0]  CRCU_MODE_CCITT   = 2'h1;
   localparam logic [1:0]  CRCU_MODE_CRC32   = 2'h2;

   localparam logic [15:0] CRCU_POLY_CRC16   = 16'h8005;
   localparam logic [15:0] CRCU_POLY_CCITT   = 16'h1021;
   localparam logic [31:0] CRCU_POLY_CRC32   = 32'h04C1_1DB7;

   // write size, coded as byte count minus one
   localparam logic [1:0]  CRCU_SZ_BYTE      = 2'h0;
   localparam logic [1:0]  CRCU_SZ_HALF      = 2'h1;
   localparam logic [1:0]  CRCU_SZ_WORD      = 2'h3;

   localparam logic [3:0]  CRCU_STRB_HALF    = 4'h3;
   localparam logic [3:0]  CRCU_STRB_WORD    = 4'hF;
   localparam logic [3:0]  CRCU_STRB_NONE    = 4'h0;

   localparam int          CRCU_BUF_DEPTH    = 2;

   typedef enum logic {CRCU_IDLE, CRCU_RUN} crcu_state_t;

endpackage

// File: hdl/crcu_word_if.sv
`timescale 1ns/1ns
interface crcu_word_if;
   logic [31:0] data;
   logic [1:0]  size;
   logic        valid;
   logic        ready;

   modport src (output data, output size, output valid, input ready);
   modport snk (input data, input size, input valid, output ready);
endinterface

// File: hdl/crcu_buf.sv
`timescale 1ns/1ns
module crcu_buf
   import crcu_pkg::*;
(
   input wire logic    pclk,
   input wire logic    presetn,
   input wire logic    flush,
   crcu_word_if.snk    fill,
   crcu_word_if.src    drain
);
   logic [31:0] data_ff [CRCU_BUF_DEPTH];
   logic [1:0]  size_ff [CRCU_BUF_DEPTH];
   logic        wr_ptr_ff;
   logic        rd_ptr_ff;
   logic [1:0]  cnt_ff;
   logic        push;
   logic        pop;

   assign fill.ready  = (cnt_ff != 2'(CRCU_BUF_DEPTH));
   assign drain.valid = (cnt_ff != 2'h0);
   assign drain.data  = data_ff[rd_ptr_ff];
   assign drain.size  = size_ff[rd_ptr_ff];
   assign push        = fill.valid & fill.ready;
   assign pop         = drain.valid & drain.ready;

   genvar e;
   generate
      for (e = 0; e < CRCU_BUF_DEPTH; e++) begin : g_entry
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               data_ff[e] <= 32'h0000_0000;
               size_ff[e] <= CRCU_SZ_BYTE;
            end else if (push && (wr_ptr_ff == 1'(e))) begin
               data_ff[e] <= fill.data;
               size_ff[e] <= fill.size;
            end
         end
      end
   endgenerate

   // flush wins: a seed reload discards anything still queued
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= 2'h0;
      end else if (flush) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_ff <= ~wr_ptr_ff;
         end
         if (pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// File: hdl/crcu_top.sv
`timescale 1ns/1ns
module crcu_top
   import crcu_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   logic [CRCU_CTRL_W-1:0] ctrl_ff;
   logic [31:0]            seed_ff;
   logic [31:0]            crc_ff;
   logic [31:0]            nxt_crc;
   logic [31:0]            word_ff;
   logic [31:0]            nxt_word;
   logic [1:0]             left_ff;
   logic [1:0]             nxt_left;
   crcu_state_t            state_ff;
   crcu_state_t            nxt_state;
   logic [31:0]            prdata_ff;
   logic                   pready_ff;
   logic                   pslverr_ff;

   logic                   acc;
   logic                   commit;
   logic                   hit;
   logic                   is_data;
   logic                   stall;
   logic                   flush;
   logic [31:0]            rd_val;
   logic [31:0]            sum_out;
   logic [1:0]             wr_size;
   logic [1:0]             mode;

   crcu_word_if in_if ();
   crcu_word_if out_if ();

   crcu_buf u_buf (
      .pclk    (pclk),
      .presetn (presetn),
      .flush   (flush),
      .fill    (in_if),
      .drain   (out_if)
   );

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
   assign mode    = ctrl_ff[CRCU_MODE_LSB +: 2];

   // one byte of the running remainder, msb first
   function automatic logic [31:0] crcu_step(input logic [31:0] c,
                                             input logic [7:0]  d,
                                             input logic [1:0]  m);
      logic [31:0] r;
      logic        fb;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (m == CRCU_MODE_CRC16) begin
            fb = r[15] ^ d[7-i];
            r  = {16'h0000, r[14:0], 1'b0} ^ (fb ? {16'h0000, CRCU_POLY_CRC16} : 32'h0000_0000);
         end else if (m == CRCU_MODE_CCITT) begin
            fb = r[15] ^ d[7-i];
            r  = {16'h0000, r[14:0], 1'b0} ^ (fb ? {16'h0000, CRCU_POLY_CCITT} : 32'h0000_0000);
         end else begin
            fb = r[31] ^ d[7-i];
            r  = {r[30:0], 1'b0} ^ (fb ? CRCU_POLY_CRC32 : 32'h0000_0000);
         end
      end
      return r;
   endfunction

   // input transforms, applied before the word enters the buffer
   function automatic logic [31:0] crcu_din(input logic [31:0]            d,
                                            input logic [1:0]             sz,
                                            input logic [CRCU_CTRL_W-1:0] c);
      logic [31:0] r;
      logic [31:0] t;
      r = d;
      if (c[CRCU_DAT_BIT_REV]) begin
         t = r;
         for (int b = 0; b < 32; b++) begin
            r[b] = t[(b & ~7) + 7 - (b & 7)];
         end
      end
      if (c[CRCU_DAT_BYTE_REV]) begin
         if (sz == CRCU_SZ_HALF) begin
            r = {16'h0000, r[7:0], r[15:8]};
         end else if (sz == CRCU_SZ_WORD) begin
            r = {r[7:0], r[15:8], r[23:16], r[31:24]};
         end
      end
      if (c[CRCU_DAT_CMPL]) begin
         r = ~r;
      end
      return r;
   endfunction

   // size from byte strobes; a master without strobes writes whole words
   always_comb begin
      if (pstrb == CRCU_STRB_WORD || pstrb == CRCU_STRB_NONE) begin
         wr_size = CRCU_SZ_WORD;
      end else if (pstrb == CRCU_STRB_HALF) begin
         wr_size = CRCU_SZ_HALF;
      end else begin
         wr_size = CRCU_SZ_BYTE;
      end
   end

   // output view of the remainder
   always_comb begin
      logic [31:0] s;
      logic [31:0] t;
      t = 32'h0000_0000;
      s = (mode == CRCU_MODE_CRC16 || mode == CRCU_MODE_CCITT) ?
          {16'h0000, crc_ff[15:0]} : crc_ff;
      if (ctrl_ff[CRCU_SUM_BIT_REV]) begin
         t = s;
         for (int b = 0; b < 32; b++) begin
            if (mode == CRCU_MODE_CRC16 || mode == CRCU_MODE_CCITT) begin
               s[b] = (b < 16) ? t[15-b] : 1'b0;
            end else begin
               s[b] = t[31-b];
            end
         end
      end
      if (ctrl_ff[CRCU_SUM_BYTE_REV]) begin
         if (mode == CRCU_MODE_CRC16 || mode == CRCU_MODE_CCITT) begin
            s = {16'h0000, s[7:0], s[15:8]};
         end else begin
            s = {s[7:0], s[15:8], s[23:16], s[31:24]};
         end
      end
      if (ctrl_ff[CRCU_SUM_CMPL]) begin
         if (mode == CRCU_MODE_CRC16 || mode == CRCU_MODE_CCITT) begin
            s = {16'h0000, ~s[15:0]};
         end else begin
            s = ~s;
         end
      end
      sum_out = s;
   end

   // address decode and read mux
   always_comb begin
      hit     = 1'b1;
      is_data = 1'b0;
      rd_val  = 32'h0000_0000;
      if (paddr == CRCU_OFS_CTRL) begin
         rd_val = {24'h00_0000, ctrl_ff};
      end else if (paddr == CRCU_OFS_SEED) begin
         rd_val = seed_ff;
      end else if (paddr == CRCU_OFS_SUM) begin
         rd_val = sum_out;
      end else if (paddr == CRCU_OFS_DATA) begin
         is_data = 1'b1;
      end else if (paddr == CRCU_OFS_STAT) begin
         rd_val[CRCU_STAT_BUSY] = (state_ff == CRCU_RUN) | out_if.valid;
      end else begin
         hit = 1'b0;
      end
   end

   assign acc    = psel & penable & ~pready_ff;
   assign commit = psel & penable & pready_ff;
   // a data write with the buffer full waits for space
   assign stall  = pwrite & is_data & ~in_if.ready;
   assign flush  = commit & pwrite & hit & (paddr == CRCU_OFS_SEED);

   // every APB write to DATA takes this path; each simply waits out the stall
   assign in_if.valid = commit & pwrite & is_data;
   assign in_if.data  = crcu_din(pwdata, wr_size, ctrl_ff);
   assign in_if.size  = wr_size;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= acc & ~stall;
         pslverr_ff <= acc & ~stall & ~hit;
         if (acc && !stall) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CRCU_CTRL_RST;
         seed_ff <= CRCU_SEED_RST;
      end else if (commit && pwrite && hit) begin
         if (paddr == CRCU_OFS_CTRL) begin
            ctrl_ff <= pwdata[CRCU_CTRL_W-1:0];
         end else if (paddr == CRCU_OFS_SEED) begin
            seed_ff <= pwdata;
         end
      end
   end

   // engine: first byte folds in the cycle the entry is taken, then one per clock
   assign out_if.ready = (state_ff == CRCU_IDLE);

   always_comb begin
      nxt_crc   = crc_ff;
      nxt_word  = word_ff;
      nxt_left  = left_ff;
      nxt_state = state_ff;
      case (state_ff)
         CRCU_IDLE: begin
            if (out_if.valid) begin
               nxt_crc  = crcu_step(crc_ff, out_if.data[7:0], mode);
               nxt_word = {8'h00, out_if.data[31:8]};
               nxt_left = out_if.size;
               if (out_if.size != CRCU_SZ_BYTE) begin
                  nxt_state = CRCU_RUN;
               end
            end
         end
         CRCU_RUN: begin
            nxt_crc  = crcu_step(crc_ff, word_ff[7:0], mode);
            nxt_word = {8'h00, word_ff[31:8]};
            nxt_left = left_ff - 2'h1;
            if (left_ff == 2'h1) begin
               nxt_state = CRCU_IDLE;
            end
         end
         default: begin
            nxt_state = CRCU_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_ff   <= CRCU_SEED_RST;
         word_ff  <= 32'h0000_0000;
         left_ff  <= 2'h0;
         state_ff <= CRCU_IDLE;
      end else if (flush) begin
         crc_ff   <= pwdata;
         word_ff  <= 32'h0000_0000;
         left_ff  <= 2'h0;
         state_ff <= CRCU_IDLE;
      end else begin
         crc_ff   <= nxt_crc;
         word_ff  <= nxt_word;
         left_ff  <= nxt_left;
         state_ff <= nxt_state;
      end
   end
endmodule

// File: sim/crcu_sva.sv
`timescale 1ns/1ns
module crcu_sva
   import crcu_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   logic [7:0] ctrl_ff;

   // shadow of control, seen only through completed writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CRCU_CTRL_RST;
      end else if (psel && penable && pready && pwrite && paddr == CRCU_OFS_CTRL) begin
         ctrl_ff <= pwdata[7:0];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_start;
      psel && $rose(penable);
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence

   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready held too long");
   property p_in_acc; pready |-> psel && penable; endproperty
   a_in_acc: assert property (p_in_acc) else $error("pready outside access");
   property p_wait; s_start |-> !pready; endproperty
   a_wait: assert property (p_wait) else $error("no wait state");
   property p_reg; s_start ##0 !(pwrite && paddr == CRCU_OFS_DATA) |-> ##1 pready; endproperty
   a_reg: assert property (p_reg) else $error("register access late");
   property p_stall; s_start ##0 (pwrite && paddr == CRCU_OFS_DATA) |-> ##[1:10] pready;
   endproperty
   a_stall: assert property (p_stall) else $error("data write stalled too long");
   property p_err; s_done ##0 (paddr > CRCU_OFS_STAT) |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped access not flagged");
   property p_ok; s_done ##0 (paddr <= CRCU_OFS_STAT && paddr[1:0] == 2'b00) |-> !pslverr;
   endproperty
   a_ok: assert property (p_ok) else $error("mapped access flagged");
   property p_w16; s_done ##0 (!pwrite && paddr == CRCU_OFS_SUM && !ctrl_ff[1])
      |-> prdata[31:16] == 16'h0000; endproperty
   a_w16: assert property (p_w16) else $error("16-bit sum has upper bits");
   property p_ctrl; s_done ##0 (!pwrite && paddr == CRCU_OFS_CTRL) |-> prdata == {24'h0, ctrl_ff};
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
endmodule

bind crcu_top crcu_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

// File: sim/crcu_apb_mst.sv
`timescale 1ns/1ns
module crcu_apb_mst (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   end

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      pstrb  <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle budget here: the bench watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released data must not look like the last word
      pwdata  <= ~d;
   endtask
endmodule

// File: sim/crcu_tb_top.sv
`timescale 1ns/1ns
module crcu_tb_top
   import crcu_pkg::*;
;
   typedef struct {logic [7:0] c; logic [31:0] s; logic [31:0] d; logic [3:0] b;} crcu_row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv, ex;
   logic [3:0]  pstrb;
   int          n_fail = 0;
   int          checked = 0;
   crcu_row_t   rows [8] = '{
      '{8'h00, 32'h0000_FFFF, 32'h1234_5678, 4'hF}, '{8'h01, 32'h0000_1D0F, 32'h0000_A5C3, 4'h3},
      '{8'h02, 32'hFFFF_FFFF, 32'h0000_0031, 4'h1}, '{8'h03, 32'h0000_0000, 32'hDEAD_BEEF, 4'h0},
      '{8'h1C, 32'h0000_0000, 32'hCAFE_F00D, 4'hF}, '{8'hE2, 32'hFFFF_FFFF, 32'h0102_0304, 4'h3},
      '{8'hE0, 32'h0000_FFFF, 32'h0000_0081, 4'h7}, '{8'h0D, 32'h0000_0000, 32'h0000_3C5A, 4'h3}};

   crcu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   crcu_apb_mst m (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb));

   function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] d, logic [1:0] md);
      logic [31:0] p;
      p = md[1] ? CRCU_POLY_CRC32 : {16'h0000, md[0] ? CRCU_POLY_CCITT : CRCU_POLY_CRC16};
      for (int i = 7; i >= 0; i--) begin
         c = ((md[1] ? c[31] : c[15]) ^ d[i]) ? ((c << 1) ^ p) : (c << 1);
      end
      return md[1] ? c : {16'h0000, c[15:0]};
   endfunction

   function automatic logic [31:0] run(crcu_row_t r);
      logic [31:0] d, t, c;
      int n;
      n = (r.b == CRCU_STRB_HALF) ? 2 : (r.b == CRCU_STRB_WORD || r.b == CRCU_STRB_NONE) ? 4 : 1;
      d = r.c[CRCU_DAT_BIT_REV] ? 32'({<<8{32'({<<{r.d}})}}) : r.d;
      t = d;
      for (int k = 0; k < n; k++) begin
         if (r.c[CRCU_DAT_BYTE_REV]) d[8*k+:8] = t[8*(n-1-k)+:8];
      end
      d = r.c[CRCU_DAT_CMPL] ? ~d : d;
      c = r.c[1] ? r.s : {16'h0000, r.s[15:0]};
      for (int k = 0; k < n; k++) begin
         c = fold(c, d[8*k+:8], r.c[1:0]);
      end
      if (r.c[CRCU_SUM_BIT_REV]) c = r.c[1] ? 32'({<<{c}}) : {16'h0, 16'({<<{c[15:0]}})};
      if (r.c[CRCU_SUM_BYTE_REV]) c = r.c[1] ? 32'({<<8{c}}) : {16'h0, c[7:0], c[15:8]};
      if (r.c[CRCU_SUM_CMPL]) c = r.c[1] ? ~c : {16'h0, ~c[15:0]};
      return c;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      m.xfer(w, a, d, s, rdv, erv);
   endtask

   // sum is final only once the busy flag has dropped
   task automatic settle();
      do begin
         acc(1'b0, CRCU_OFS_STAT, 32'h0, 4'h0);
      end while (rdv[CRCU_STAT_BUSY] !== 1'b0);
      acc(1'b0, CRCU_OFS_SUM, 32'h0, 4'h0);
   endtask

   task close_out();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   initial begin
      #1_000_000;
      n_fail++;
      close_out();
   end

   initial begin
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      acc(1'b0, CRCU_OFS_CTRL, 32'h0, 4'h0);
      chk("ctrl_rst", rdv, {24'h0, CRCU_CTRL_RST});
      acc(1'b0, CRCU_OFS_SEED, 32'h0, 4'h0);
      chk("seed_rst", rdv, CRCU_SEED_RST);
      foreach (rows[i]) begin
         acc(1'b1, CRCU_OFS_CTRL, {24'h0, rows[i].c}, 4'hF);
         acc(1'b1, CRCU_OFS_SEED, rows[i].s, 4'hF);
         acc(1'b1, CRCU_OFS_DATA, rows[i].d, rows[i].b);
         settle();
         chk("sum_row", rdv, run(rows[i]));
      end
      acc(1'b1, CRCU_OFS_CTRL, 32'h0000_0002, 4'hF);
      acc(1'b1, CRCU_OFS_SEED, 32'hFFFF_FFFF, 4'hF);
      ex = 32'hFFFF_FFFF;
      for (int k = 0; k < 3; k++) begin
         acc(1'b1, CRCU_OFS_DATA, 32'h5A00_00C3 + k, 4'hF);
         for (int j = 0; j < 4; j++) ex = fold(ex, 8'((32'h5A00_00C3 + k) >> (8 * j)), 2'h2);
      end
      settle();
      chk("sum_b2b", rdv, ex);
      acc(1'b1, CRCU_OFS_DATA, 32'h1357_9BDF, 4'hF);
      acc(1'b1, CRCU_OFS_DATA, 32'h2468_ACE0, 4'hF);
      acc(1'b1, CRCU_OFS_SEED, 32'h0000_1234, 4'hF);
      acc(1'b1, CRCU_OFS_DATA, 32'h0000_0042, 4'h1);
      settle();
      chk("sum_reseed", rdv, fold(32'h0000_1234, 8'h42, 2'h2));
      acc(1'b1, 8'h20, 32'h0, 4'hF);
      chk("err_wr", {31'h0, erv}, 32'h1);
      acc(1'b0, CRCU_OFS_DATA, 32'h0, 4'h0);
      chk("data_rd", rdv, 32'h0);
      // reset with the engine idle, a non-default control and remainder in place
      acc(1'b1, CRCU_OFS_CTRL, 32'h0000_00E2, 4'hF);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      acc(1'b0, CRCU_OFS_CTRL, 32'h0, 4'h0);
      chk("ctrl_rst2", rdv, {24'h0, CRCU_CTRL_RST});
      acc(1'b0, CRCU_OFS_SUM, 32'h0, 4'h0);
      chk("sum_rst2", rdv, CRCU_SEED_RST);
      close_out();
   end
endmodule
